/* common/rsef_consts.vh */
`ifndef RSEF_CONSTS_VH
`define RSEF_CONSTS_VH
// register addresses on the serial control port
`define RSEF_ADDR_RX_ERR      7'h18
`define RSEF_ADDR_RX_MASK     7'h19
`define RSEF_ADDR_SRC_ERR     7'h1a
// receiver error bit positions
`define RSEF_RX_VALIDITY      7
`define RSEF_RX_EMPHASIS      6
`define RSEF_RX_NONAUDIO      5
`define RSEF_RX_PREAMBLE      4
`define RSEF_RX_CHECKSUM      3
`define RSEF_RX_ABSENT        2
`define RSEF_RX_CODING        1
`define RSEF_RX_LOCK          0
// converter error bit positions
`define RSEF_SRC_STARVE       3
`define RSEF_SRC_CLIP_L       2
`define RSEF_SRC_CLIP_R       1
`define RSEF_SRC_MUTED        0
// mask reset value and converter reserved-bit read mask
`define RSEF_MASK_RESET       8'h00
`define RSEF_SRC_RES_MASK     8'h0f
`endif

/* tb/rsef_error_flags_properties.sv */
`timescale 1ns/100ps
module rsef_error_flags_chk (
    // clock and reset
    input wire       mclk,
    input wire       rst_n,
    // register port
    input wire [6:0] reg_addr,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // watched conditions and event
    input wire       rx_pll_locked,
    input wire       status_checksum_fail,
    input wire       left_clip_flag,
    input wire       rx_error_event
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [7:0] mask_q;
    // shadow mask, so the gate is judged from the ports alone
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            mask_q <= 8'h00;
        else if (reg_wr && reg_addr == 7'h19)
            mask_q <= reg_wdata;
    end
    sequence rd_s(logic [6:0] a);
        reg_rd && reg_addr == a;
    endsequence
    unmapped_zero_a: assert property (
        reg_rd && (reg_addr < 7'h18 || reg_addr > 7'h1a) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    reserved_zero_a: assert property (rd_s(7'h1a) |=> reg_rdata[7:4] == 4'h0)
        else $error("converter reserved bits set");
    mask_readback_a: assert property (rd_s(7'h19) |=> reg_rdata == $past(mask_q))
        else $error("mask readback wrong");
    mask_gate_a: assert property (mask_q == 8'h00 |-> !rx_error_event)
        else $error("event with mask clear");
    lock_high_a: assert property (rx_pll_locked[*6] ##0 rd_s(7'h18) |=> reg_rdata[0])
        else $error("lock bit low while locked");
    lock_low_a: assert property ((!rx_pll_locked)[*6] ##0 rd_s(7'h18) |=> !reg_rdata[0])
        else $error("lock bit high while unlocked");
    checksum_clear_a: assert property (
        (!status_checksum_fail)[*7] ##0 rd_s(7'h18) ##1 rd_s(7'h18) |=> !reg_rdata[3])
        else $error("checksum flag not cleared by read");
    clip_clear_a: assert property (
        (!left_clip_flag)[*7] ##0 rd_s(7'h1a) ##1 rd_s(7'h1a) |=> !reg_rdata[2])
        else $error("left clip flag not cleared by read");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
endmodule
bind rsef_error_flags rsef_error_flags_chk u_chk (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rx_pll_locked(rx_pll_locked),
    .status_checksum_fail(status_checksum_fail), .left_clip_flag(left_clip_flag),
    .rx_error_event(rx_error_event));

/* tb/rsef_error_flags_tb.sv */
`timescale 1ns/100ps
module rsef_error_flags_tb;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    wire  [7:0] reg_rdata;
    wire        rx_error_event;
    // receiver conditions laid out at their register bit positions
    logic [7:0] rxc = 8'h00;
    logic [1:0] ptype = 2'h0;
    logic [3:0] srcc = 4'h0;
    int         n_mismatch = 0;
    int         compares = 0;
    always #12.5 mclk = ~mclk;
    rsef_error_flags dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rx_validity_flag(rxc[7]), .rx_emphasis(rxc[6]), .rx_cs_bit1(rxc[5]),
        .rx_preamble_seen(rxc[4]), .rx_preamble_type(ptype), .status_checksum_fail(rxc[3]),
        .input_absent_flag(rxc[2]), .rx_coding_fault(rxc[1]), .rx_pll_locked(rxc[0]),
        .src_clock_starved(srcc[3]), .left_clip_flag(srcc[2]), .right_clip_flag(srcc[1]),
        .src_acquiring(srcc[0]), .rx_error_event(rx_error_event));
    task automatic tally_and_finish();
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask
    // strobes stay up between back-to-back calls of the same task, dropped by idle or by the other task
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge mclk);
        #1;
        cmp8(reg_rdata, exp);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_rd = 1'b0;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk);
        #1;
    endtask
    task automatic idle(input int n);
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic t_mask();
        wr(7'h19, 8'ha5);
        wr(7'h18, 8'hff);
        wr(7'h1a, 8'hff);
        rd(7'h19, 8'ha5);
        rd(7'h18, 8'h00);
        rd(7'h1a, 8'h00);
        rd(7'h05, 8'h00);
        idle(1);
        cmp1(rx_error_event, 1'b0);
    endtask
    task automatic t_sticky();
        wr(7'h19, 8'h0a);
        rxc = 8'h0a;
        idle(1);
        rxc = 8'h00;
        idle(5);
        cmp1(rx_error_event, 1'b1);
        rd(7'h18, 8'h0a);
        rd(7'h18, 8'h00);
        idle(1);
        cmp1(rx_error_event, 1'b0);
    endtask
    task automatic t_state();
        wr(7'h19, 8'hff);
        rxc = 8'hf5;
        ptype = 2'h1;
        idle(6);
        cmp1(rx_error_event, 1'b1);
        rd(7'h18, 8'hf5);
        rd(7'h18, 8'hf5);
        idle(1);
        cmp1(rx_error_event, 1'b0);
        ptype = 2'h2;
        idle(6);
        cmp1(rx_error_event, 1'b1);
        rxc = 8'hf4;
        idle(6);
        rd(7'h18, 8'hf4);
        rxc = 8'hd4;
        idle(6);
        cmp1(rx_error_event, 1'b1);
        wr(7'h19, 8'h00);
        idle(1);
        cmp1(rx_error_event, 1'b0);
    endtask
    task automatic t_src();
        srcc = 4'hf;
        idle(1);
        srcc = 4'h9;
        idle(5);
        rd(7'h1a, 8'h0f);
        rd(7'h1a, 8'h09);
        srcc = 4'h0;
        idle(5);
        rd(7'h1a, 8'h00);
        rd(7'h1a, 8'h00);
    endtask
    // mid-run reset drops the mask and every latched flag
    task automatic t_reset();
        wr(7'h19, 8'h08);
        rxc = 8'h08;
        idle(1);
        rxc = 8'h00;
        idle(4);
        cmp1(rx_error_event, 1'b1);
        rst_n = 1'b0;
        idle(2);
        cmp1(rx_error_event, 1'b0);
        rst_n = 1'b1;
        rd(7'h19, 8'h00);
        rd(7'h18, 8'h00);
        idle(1);
    endtask
    // hang guard: the run needs only about 80 cycles
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge mclk);
        #1 rst_n = 1'b1;
        rd(7'h18, 8'h00);
        t_mask();
        t_sticky();
        t_state();
        t_src();
        t_reset();
        tally_and_finish();
    end
endmodule

/* verilog/rsef_error_flags.v */
`timescale 1ns/100ps
`include "rsef_consts.vh"
// How it works
// - bit 7 of the receiver error register mirrors the incoming validity bit.
// - bit 6 follows the emphasis state and raises an event only when it changes.
// - bit 5 follows channel status bit 1 and raises an event on audio/non-audio change.
// - bit 4 flags a non-audio preamble and raises an event when it appears, vanishes or changes type.
// - bit 3 latches a checksum failure until the receiver error register is read.
// - bit 2 follows stream absence and raises an event only when it changes.
// - bit 1 latches a coding or parity fault until the register is read.
// - bit 0 follows receiver lock, is unchanged by reads, with events on change.
// - the mask register at 0x19 is bit-aligned, a 1 lets the flag interrupt.
// - bit 3 of the converter error register shows converter clock starvation.
// - bit 2 latches left clipping until the converter register is read.
// - bit 1 latches right clipping until the converter register is read.
// - bit 0 shows the output muted until the converter reaches slow tracking.
// - converter bits 7..4 are reserved zero and the register is read-only.
module rsef_error_flags (
    // clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // register port
    input  wire [6:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // raw receiver conditions (asynchronous)
    input  wire       rx_validity_flag,
    input  wire       rx_emphasis,
    input  wire       rx_cs_bit1,
    input  wire       rx_preamble_seen,
    input  wire [1:0] rx_preamble_type,
    input  wire       status_checksum_fail,
    input  wire       input_absent_flag,
    input  wire       rx_coding_fault,
    input  wire       rx_pll_locked,
    // raw converter conditions (asynchronous)
    input  wire       src_clock_starved,
    input  wire       left_clip_flag,
    input  wire       right_clip_flag,
    input  wire       src_acquiring,
    // event to global interrupt logic
    output wire       rx_error_event
);
    // two-flop synchronisers for all raw conditions
    localparam NS = 14;
    wire [NS-1:0] raw_in = {rx_validity_flag, rx_emphasis, rx_cs_bit1, rx_preamble_seen,
                            rx_preamble_type, status_checksum_fail, input_absent_flag,
                            rx_coding_fault, rx_pll_locked, src_clock_starved,
                            left_clip_flag, right_clip_flag, src_acquiring};
    reg  [NS-1:0] sync1_q;
    reg  [NS-1:0] sync2_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= {NS{1'b0}};
            sync2_q <= {NS{1'b0}};
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    wire       s_valid   = sync2_q[13];
    wire       s_emph    = sync2_q[12];
    wire       s_nonaud  = sync2_q[11];
    wire       s_pre     = sync2_q[10];
    wire [1:0] s_pretype = sync2_q[9:8];
    wire       s_crc     = sync2_q[7];
    wire       s_absent  = sync2_q[6];
    wire       s_coding  = sync2_q[5];
    wire       s_lock    = sync2_q[4];
    wire       s_starve  = sync2_q[3];
    wire       s_clip_l  = sync2_q[2];
    wire       s_clip_r  = sync2_q[1];
    wire       s_acq     = sync2_q[0];

    // read strobes clear sticky bits of the register just read
    wire rd_rx  = reg_rd & (reg_addr == `RSEF_ADDR_RX_ERR);
    wire rd_src = reg_rd & (reg_addr == `RSEF_ADDR_SRC_ERR);

    wire [7:0] rx_flag;
    wire [7:0] rx_evt;
    wire [7:0] src_flag;

    // preamble type change counts as a state change for bit 4
    reg [1:0] pretype_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pretype_q <= 2'h0;
        end else begin
            pretype_q <= s_pretype;
        end
    end
    wire pre_state = s_pre;
    wire pre_type_chg = s_pre & (s_pretype != pretype_q);
    // a preamble that appears or vanishes is news too, not only a type change
    wire pre_edge_evt;

    reg pre_evt_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_evt_q <= 1'b0;
        end else begin
            pre_evt_q <= pre_type_chg | (pre_evt_q & ~rd_rx);
        end
    end

    // receiver flag cells
    rsef_flag_bit #(
        .STICKY(0)
    ) u_valid (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (s_valid),
        .rd_clr  (rd_rx),
        .flag_q  (rx_flag[`RSEF_RX_VALIDITY]),
        .event_q (rx_evt[`RSEF_RX_VALIDITY])
    );
    rsef_flag_bit #(
        .STICKY(0)
    ) u_emph (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (s_emph),
        .rd_clr  (rd_rx),
        .flag_q  (rx_flag[`RSEF_RX_EMPHASIS]),
        .event_q (rx_evt[`RSEF_RX_EMPHASIS])
    );
    rsef_flag_bit #(
        .STICKY(0)
    ) u_nonaud (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (s_nonaud),
        .rd_clr  (rd_rx),
        .flag_q  (rx_flag[`RSEF_RX_NONAUDIO]),
        .event_q (rx_evt[`RSEF_RX_NONAUDIO])
    );
    rsef_flag_bit #(
        .STICKY(0)
    ) u_pre (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (pre_state),
        .rd_clr  (rd_rx),
        .flag_q  (rx_flag[`RSEF_RX_PREAMBLE]),
        .event_q (pre_edge_evt)
    );
    rsef_flag_bit #(
        .STICKY(1)
    ) u_crc (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (s_crc),
        .rd_clr  (rd_rx),
        .flag_q  (rx_flag[`RSEF_RX_CHECKSUM]),
        .event_q (rx_evt[`RSEF_RX_CHECKSUM])
    );
    rsef_flag_bit #(
        .STICKY(0)
    ) u_absent (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (s_absent),
        .rd_clr  (rd_rx),
        .flag_q  (rx_flag[`RSEF_RX_ABSENT]),
        .event_q (rx_evt[`RSEF_RX_ABSENT])
    );
    rsef_flag_bit #(
        .STICKY(1)
    ) u_coding (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (s_coding),
        .rd_clr  (rd_rx),
        .flag_q  (rx_flag[`RSEF_RX_CODING]),
        .event_q (rx_evt[`RSEF_RX_CODING])
    );
    rsef_flag_bit #(
        .STICKY(0)
    ) u_lock (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (s_lock),
        .rd_clr  (rd_rx),
        .flag_q  (rx_flag[`RSEF_RX_LOCK]),
        .event_q (rx_evt[`RSEF_RX_LOCK])
    );
    // both event sources are cleared by the same read of the receiver register
    assign rx_evt[`RSEF_RX_PREAMBLE] = pre_evt_q | pre_edge_evt;

    // converter flag cells; starvation and mute follow state
    rsef_flag_bit #(
        .STICKY(0)
    ) u_starve (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (s_starve),
        .rd_clr  (rd_src),
        .flag_q  (src_flag[`RSEF_SRC_STARVE]),
        .event_q ()
    );
    rsef_flag_bit #(
        .STICKY(1)
    ) u_clip_l (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (s_clip_l),
        .rd_clr  (rd_src),
        .flag_q  (src_flag[`RSEF_SRC_CLIP_L]),
        .event_q ()
    );
    rsef_flag_bit #(
        .STICKY(1)
    ) u_clip_r (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (s_clip_r),
        .rd_clr  (rd_src),
        .flag_q  (src_flag[`RSEF_SRC_CLIP_R]),
        .event_q ()
    );
    // mute is a level from the tracking logic; it clears itself at slow tracking
    rsef_flag_bit #(
        .STICKY(0)
    ) u_muted (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (s_acq),
        .rd_clr  (rd_src),
        .flag_q  (src_flag[`RSEF_SRC_MUTED]),
        .event_q ()
    );
    assign src_flag[7:4] = 4'h0;

    // mask register, the only writable one here
    reg [7:0] rx_mask_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_mask_q <= `RSEF_MASK_RESET;
        end else if (reg_wr && reg_addr == `RSEF_ADDR_RX_MASK) begin
            rx_mask_q <= reg_wdata;
        end
    end

    // masked OR of pending flag events
    assign rx_error_event = |(rx_evt & rx_mask_q);

    // read data registered; flags are sampled before the clear lands
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `RSEF_ADDR_RX_ERR:  reg_rdata <= rx_flag;
                `RSEF_ADDR_RX_MASK: reg_rdata <= rx_mask_q;
                `RSEF_ADDR_SRC_ERR: reg_rdata <= src_flag & `RSEF_SRC_RES_MASK;
                default:            reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule

/* verilog/rsef_flag_bit.v */
`timescale 1ns/100ps
// one flag cell: sticky event or state with change-event
module rsef_flag_bit #(
    parameter STICKY = 1
) (
    // clock and reset
    input  wire mclk,
    input  wire rst_n,
    // condition and read strobe
    input  wire cond,
    input  wire rd_clr,
    // results
    output reg  flag_q,
    output reg  event_q
);
    reg seen_q;

    // set wins over the read clear so no event is lost in that cycle
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q  <= 1'b0;
            seen_q  <= 1'b0;
            event_q <= 1'b0;
        end else if (STICKY != 0) begin
            flag_q  <= cond | (flag_q & ~rd_clr);
            event_q <= cond | (event_q & ~rd_clr);
        end else begin
            flag_q  <= cond;
            seen_q  <= cond;
            // state flags raise an event only on change; read acknowledges it
            event_q <= (cond != seen_q) | (event_q & ~rd_clr);
        end
    end
endmodule
